// >>> logic/tfrc_map.svh
/*
  Offsets, field positions, reset values and timing figures of the
  thermal fault retry controller.
  Assumes a 200 MHz system clock and a 32-bit APB register bus.
*/
`ifndef TFRC_MAP_SVH
`define TFRC_MAP_SVH

// Clock rate in MHz.
`define TFRC_CLK_MHZ       200
// Waits in microseconds; the controller turns them into cycle counts.
`define TFRC_T_COOL_US     20
`define TFRC_T_RETRY_US    500
`define TFRC_T_CLR_US      2000
// Retry limits, meant to be trimmed per application.
`define TFRC_FAST_LIMIT    3
`define TFRC_SLOW_LIMIT    2

// Register byte offsets.
`define TFRC_OFS_EVENT     12'h000
`define TFRC_OFS_MASK      12'h004
`define TFRC_OFS_STATE     12'h008

// Event bit positions, shared by event and mask registers.
`define TFRC_EV_PEAK       0
`define TFRC_EV_THERM      1
`define TFRC_EV_LATCH      2
`define TFRC_EV_W          3

// Reset value of the mask register: every event enabled.
`define TFRC_MASK_RST      3'h7

`endif

// >>> logic/tfrc_pkg.sv
/*
  Types of the thermal fault retry controller.
  Assumes tfrc_map.svh is on the include path.
*/
`include "tfrc_map.svh"

package tfrc_pkg;

  // Protection mode; the first member is the reset state.
  typedef enum logic [1:0] {
    TFRC_RUN,
    TFRC_COOL,
    TFRC_THERM,
    TFRC_LATCH
  } tfrc_mode_e;

  // Protection flags from the analog comparators.
  typedef struct packed {
    logic abs_hot;
    logic diff_hot;
    logic backup_hot;
    logic peak;
  } tfrc_flags_s;

  // Whole state of the controller.
  typedef struct packed {
    tfrc_mode_e               mode;
    logic [7:0]               fault_cnt;
    logic [31:0]              timer;
    logic [31:0]              dis_cnt;
    logic                     drive;
    logic                     latched;
    logic [`TFRC_EV_W-1:0]    events;
    logic [`TFRC_EV_W-1:0]    mask;
    logic                     irq;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } tfrc_state_s;

endpackage : tfrc_pkg

// >>> logic/tfrc_ctrl.sv
/*
  Thermal fault retry controller: gates the output stage from the
  thermal and peak-current flags, spaces retries by cool-down timers
  or temperature hysteresis, and latches off after too many faults.
  Assumes all inputs synchronous to sys_clk_i, comparator flags that
  carry their own hysteresis, and an APB master on the register port.
  Limitation: a disable long enough to clear the count does not cut short
  a cool-down or hysteresis wait already running; the stage restarts only
  when that wait has ended and the enable is back.
*/
// Behaviour
// - The output stage is forced off while the absolute thermal flag is set.
// - After an absolute shutdown, restart waits until the flag clears on cooling.
// - A differential thermal flag turns the output off until it clears again.
// - Differential shutdown acts without waiting for the peak detector.
// - The back-up thermal flag can also force the output stage off.
// - Each current peak while driving turns the output off and counts a fault.
// - The first fast_retry_limit retries restart after the short cool-down.
// - Later retries are spaced by the longer retry interval.
// - At fast plus slow faults the output latches off until a counter reset.
// - Enable held low longer than the clear time clears counter and latch.
// - Thermal shutdowns also count, and wait on hysteresis, not a timer.
// - One fault counter serves both current and thermal paths.
// - The retry limits are trimmable; 1 and 0 give fuse behaviour.
`timescale 1ns/1ps
`include "tfrc_map.svh"

module tfrc_ctrl import tfrc_pkg::*; #(
  parameter int FAST_LIMIT = `TFRC_FAST_LIMIT,                  // Fast retries.
  parameter int SLOW_LIMIT = `TFRC_SLOW_LIMIT,                  // Slow retries.
  parameter int COOL_CYC   = `TFRC_T_COOL_US * `TFRC_CLK_MHZ,   // Short wait.
  parameter int RETRY_CYC  = `TFRC_T_RETRY_US * `TFRC_CLK_MHZ,  // Long wait.
  parameter int CLR_CYC    = `TFRC_T_CLR_US * `TFRC_CLK_MHZ     // Clear time.
) (
  input  wire logic        sys_clk_i,  // System clock.
  input  wire logic        reset_i,    // Synchronous reset, high.
  input  wire logic        enable_i,   // Input enable from the controller.
  input  wire tfrc_flags_s flags_i,    // Comparator flags.
  output logic             drive_o,    // Output stage gate drive.
  output logic             latched_o,  // Latched off.
  output logic             irq_o,      // Level interrupt.
  input  wire logic        psel,       // APB select.
  input  wire logic        penable,    // APB enable.
  input  wire logic        pwrite,     // APB direction.
  input  wire logic [11:0] paddr,      // APB byte address.
  input  wire logic [31:0] pwdata,     // APB write data.
  output logic             pready,     // APB ready.
  output logic [31:0]      prdata,     // APB read data.
  output logic             pslverr     // APB error.
);

  // Fault total at which the stage latches off.
  localparam logic [7:0] TOTAL = 8'(FAST_LIMIT + SLOW_LIMIT);
  localparam logic [7:0] FAST  = 8'(FAST_LIMIT);

  // Present state, its next value and the scratch terms of the next-state logic.
  tfrc_state_s s;
  tfrc_state_s n;
  logic        hot;
  logic        clr;
  logic [7:0]  nc;
  logic [`TFRC_EV_W-1:0] ev;
  logic [`TFRC_EV_W-1:0] w1c;

  // Any thermal flag shuts down, whatever the peak detector says. The
  // comparators carry their own hysteresis, so a flag that drops means the
  // die has cooled far enough to try again.
  assign hot = flags_i.abs_hot
             | flags_i.diff_hot
             | flags_i.backup_hot;

  // Next state: protection sequence, disable clear, then register port.
  always_comb begin
    n   = s;
    ev  = '0;
    w1c = '0;
    nc  = 8'(s.fault_cnt + 8'h01);
    // A long disable is timed here; saturating keeps it from wrapping.
    clr = !enable_i && (s.dis_cnt == 32'(CLR_CYC));
    if (enable_i) begin
      n.dis_cnt = '0;
    end else if (!clr) begin
      n.dis_cnt = 32'(s.dis_cnt + 32'h1);
    end
    case (s.mode)
      TFRC_RUN: begin
        // Thermal wins over the peak so the longer wait prevails.
        if (s.drive && hot) begin
          n.fault_cnt = nc;
          ev[`TFRC_EV_THERM] = 1'b1;
          n.mode = (nc >= TOTAL) ? TFRC_LATCH : TFRC_THERM;
        end else if (s.drive && flags_i.peak) begin
          n.fault_cnt = nc;
          ev[`TFRC_EV_PEAK] = 1'b1;
          n.mode = (nc >= TOTAL) ? TFRC_LATCH : TFRC_COOL;
          // Early retries use the short wait, later ones the long.
          n.timer = (nc <= FAST) ? 32'(COOL_CYC)
                                 : 32'(RETRY_CYC);
        end
      end
      TFRC_COOL: begin
        // A die still hot after the timer keeps waiting on hysteresis.
        if (s.timer != 32'h0) begin
          n.timer = 32'(s.timer - 32'h1);
        end else if (!hot) begin
          n.mode = TFRC_RUN;
        end
      end
      TFRC_THERM: begin
        // Restart only once the comparator has dropped on cooling.
        if (!hot) begin
          n.mode = TFRC_RUN;
        end
      end
      TFRC_LATCH: begin
        n.mode = TFRC_LATCH;
      end
      default: begin
        n.mode = TFRC_RUN;
      end
    endcase
    if (n.mode == TFRC_LATCH && s.mode != TFRC_LATCH) begin
      ev[`TFRC_EV_LATCH] = 1'b1;
    end
    // Long disable: counter and latch cleared; the counter is shared.
    if (clr) begin
      n.fault_cnt = '0;
      if (s.mode == TFRC_LATCH) begin
        n.mode = TFRC_RUN;
      end
    end
    // Drive needs enable, no flag, run mode and no latch.
    n.drive = enable_i && (n.mode == TFRC_RUN) && !hot
              && !flags_i.peak;
    n.latched = (n.mode == TFRC_LATCH);

    // Register port: answer in the first access cycle.
    // Map: event flags at the first word, write one to clear; mask at the
    // second word; state at the third word, read only, with the fault count
    // in bits 15:8, latch in bit 4, drive in bit 3 and the mode in bits 1:0.
    // Data comes from the state before the edge, so a read never sees a
    // half-updated sequence. Unmapped words answer with an error and zero.
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    n.prdata  = '0;
    if (psel && !penable) begin
      n.pready = 1'b1;
      case (paddr)
        `TFRC_OFS_EVENT: n.prdata = 32'(s.events);
        `TFRC_OFS_MASK:  n.prdata = 32'(s.mask);
        `TFRC_OFS_STATE: n.prdata = {16'h0, s.fault_cnt, 3'h0,
                                     s.latched, s.drive, 1'b0, s.mode};
        default:         n.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s.pready && pwrite) begin
      if (paddr == `TFRC_OFS_EVENT) begin
        w1c = pwdata[`TFRC_EV_W-1:0];
      end
      if (paddr == `TFRC_OFS_MASK) begin
        n.mask = pwdata[`TFRC_EV_W-1:0];
      end
    end
    // A new event in the clearing cycle survives the clear.
    n.events = (s.events & ~w1c) | ev;
    n.irq    = |(n.events & n.mask);
  end

  // State register; synchronous reset puts everything to its base.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s      <= '0;
      s.mask <= `TFRC_MASK_RST;
    end else begin
      s <= n;
    end
  end

  assign drive_o   = s.drive;
  assign latched_o = s.latched;
  assign irq_o     = s.irq;
  assign pready    = s.pready;
  assign prdata    = s.prdata;
  assign pslverr   = s.pslverr;

  // Checks on the protection sequence. They share one clock and are quiet
  // during reset, since the state means nothing there.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  logic ok_in;
  assign ok_in = enable_i && !hot && !flags_i.peak;

  AST_DRIVE_GATE: assert property (
    drive_o |-> $past(ok_in) && s.mode == TFRC_RUN)
    else $error("drive high without a clean enable");
  AST_ABS_OFF: assert property (
    flags_i.abs_hot |=> !drive_o)
    else $error("drive kept on over absolute flag");
  AST_DIFF_OFF: assert property (
    flags_i.diff_hot && !flags_i.peak |=> !drive_o)
    else $error("drive kept on over differential flag");
  AST_BACKUP_OFF: assert property (
    flags_i.backup_hot |=> !drive_o)
    else $error("drive kept on over back-up flag");
  AST_PEAK_COUNT: assert property (
    drive_o && flags_i.peak && !hot
    |=> s.fault_cnt == 8'($past(s.fault_cnt) + 8'h01) && !drive_o)
    else $error("peak did not count a fault");
  AST_THERM_COUNT: assert property (
    drive_o && hot |=> s.fault_cnt == 8'($past(s.fault_cnt) + 8'h01))
    else $error("thermal fault not counted");
  AST_THERM_HOLD: assert property (
    s.mode == TFRC_THERM && hot |=> s.mode == TFRC_THERM && !drive_o)
    else $error("restart before cooling");
  AST_COOL_SHORT: assert property (
    s.mode == TFRC_COOL && $past(s.mode) != TFRC_COOL && s.fault_cnt <= FAST
    |-> s.timer == 32'(COOL_CYC))
    else $error("short wait not loaded");
  AST_COOL_LONG: assert property (
    s.mode == TFRC_COOL && $past(s.mode) != TFRC_COOL && s.fault_cnt > FAST
    |-> s.timer == 32'(RETRY_CYC))
    else $error("long wait not loaded");
  AST_LATCH: assert property (
    s.fault_cnt >= TOTAL |-> latched_o && !drive_o)
    else $error("fault total reached without latch");
  AST_CLEAR: assert property (
    !enable_i && s.dis_cnt == 32'(CLR_CYC)
    |=> s.fault_cnt == 8'h00 && s.mode != TFRC_LATCH)
    else $error("long disable did not clear");

  // Wait states and their exits. Each mode is checked on its own so a
  // broken transition points at the state that owns it.
  AST_WAIT_NO_DRIVE: assert property (
    s.mode != TFRC_RUN |-> !drive_o)
    else $error("drive high outside run mode");

  // A thermal fault below the total enters the hysteresis wait, not a timer.
  AST_THERM_ENTRY: assert property (
    drive_o && hot && 8'(s.fault_cnt + 8'h01) < TOTAL |=> s.mode == TFRC_THERM)
    else $error("thermal fault did not enter the hysteresis wait");

  // A peak below the total enters the timed cool-down.
  AST_PEAK_ENTRY: assert property (
    drive_o && flags_i.peak && !hot && 8'(s.fault_cnt + 8'h01) < TOTAL
    |=> s.mode == TFRC_COOL)
    else $error("peak did not start the cool-down");

  // The fault that reaches the total latches the stage off at once.
  AST_LATCH_ENTRY: assert property (
    drive_o && (hot || flags_i.peak) && 8'(s.fault_cnt + 8'h01) >= TOTAL
    |=> latched_o)
    else $error("final fault did not latch");

  // The cool-down timer steps down by one each cycle while it runs.
  AST_COOL_STEP: assert property (
    s.mode == TFRC_COOL && s.timer != 32'h0
    |=> s.mode == TFRC_COOL && s.timer == 32'($past(s.timer) - 32'h1))
    else $error("cool-down timer did not step");

  // Timer out and die cool: the next cycle is back in run mode.
  AST_COOL_EXIT: assert property (
    s.mode == TFRC_COOL && s.timer == 32'h0 && !hot |=> s.mode == TFRC_RUN)
    else $error("cool-down did not end");

  // A hot die keeps the cool-down going past the timer; the longer wait wins.
  AST_COOL_HOT: assert property (
    s.mode == TFRC_COOL && hot |=> s.mode == TFRC_COOL)
    else $error("cool-down left while the die is hot");

  // Once every thermal flag has dropped the hysteresis wait ends.
  AST_THERM_EXIT: assert property (
    s.mode == TFRC_THERM && !hot |=> s.mode == TFRC_RUN)
    else $error("hysteresis wait did not end");

  // The latch only lets go through the long-disable clear.
  AST_LATCH_HOLD: assert property (
    s.mode == TFRC_LATCH && !clr |=> s.mode == TFRC_LATCH)
    else $error("latch released without a clear");

  // The count never passes the total, since the latch stops it there.
  AST_CNT_BOUND: assert property (
    s.fault_cnt <= TOTAL)
    else $error("fault count beyond the total");

  // A flag or peak while the stage is already off is not a new fault.
  AST_IDLE_NO_COUNT: assert property (
    !drive_o && !clr |=> s.fault_cnt == $past(s.fault_cnt))
    else $error("fault counted while the stage was off");

  // Enable low takes the stage off at the next edge.
  AST_EN_OFF: assert property (
    !enable_i |=> !drive_o)
    else $error("drive high with enable low");

  // In run mode with a clean enable the stage comes on at the next edge.
  AST_RUN_DRIVE: assert property (
    s.mode == TFRC_RUN && enable_i && !hot && !flags_i.peak |=> drive_o)
    else $error("drive withheld in run mode");

  // Disable timer: cleared by enable, saturated at the clear time.
  AST_DIS_ZERO: assert property (
    enable_i |=> s.dis_cnt == 32'h0)
    else $error("disable timer not cleared by enable");
  AST_DIS_SAT: assert property (
    !enable_i && s.dis_cnt == 32'(CLR_CYC) |=> s.dis_cnt == 32'(CLR_CYC))
    else $error("disable timer ran past the clear time");

  // Event flags are sticky: only a written one clears a bit, and a new
  // event in the clearing cycle wins over the clear.
  logic [`TFRC_EV_W-1:0] ev_kept;
  logic [`TFRC_EV_W-1:0] wr_bits;
  assign ev_kept = s.events & ~w1c;
  assign wr_bits = pwdata[`TFRC_EV_W-1:0];

  AST_EVENT_KEEP: assert property (
    1'b1 |=> (s.events & $past(ev_kept)) == $past(ev_kept))
    else $error("event flag lost without a clear");
  AST_EVENT_SET: assert property (
    ev != '0 |=> (s.events & $past(ev)) == $past(ev))
    else $error("event not recorded");
  AST_IRQ_LEVEL: assert property (
    irq_o == |(s.events & s.mask))
    else $error("interrupt out of step with events and mask");

  // Register port: one answer per setup, standing a single cycle.
  AST_SETUP_ANSWER: assert property (
    psel && !penable |=> pready)
    else $error("setup not answered");
  AST_READY_PULSE: assert property (
    pready && penable |=> !pready)
    else $error("ready held past the access cycle");
  AST_IDLE_BUS: assert property (
    !pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside an answer");
  AST_UNMAPPED: assert property (
    psel && !penable && paddr != `TFRC_OFS_EVENT && paddr != `TFRC_OFS_MASK
    && paddr != `TFRC_OFS_STATE |=> pslverr && prdata == 32'h0)
    else $error("unmapped word answered without an error");
  AST_MASK_WRITE: assert property (
    psel && penable && pready && pwrite && paddr == `TFRC_OFS_MASK
    |=> s.mask == $past(wr_bits))
    else $error("mask write lost");

endmodule : tfrc_ctrl

// >>> sim/tfrc_mcu_model.sv
/*
  Microcontroller model that drives the input enable of the controller.
  Assumes it shares the system clock and can observe the gate drive.
*/
`timescale 1ns/1ps
module tfrc_mcu_model #(
  parameter int CAP = 64  // Drive drops tolerated before giving up.
) (
  input  wire logic sys_clk_i,  // System clock.
  input  wire logic reset_i,    // Synchronous reset, high.
  input  wire logic on_i,       // Load wanted on.
  input  wire logic drive_i,    // Observed gate drive.
  output logic      enable_o    // Input enable.
);
  logic [7:0] falls;
  logic       seen;
  // Count drive drops so a stuck short cannot toggle the load forever.
  always_ff @(posedge sys_clk_i) begin
    seen <= drive_i;
    if (reset_i) begin
      falls <= 8'h00;
    end else if (seen && !drive_i && falls < CAP) begin
      falls <= falls + 8'h01;
    end
  end
  // Past the cap the load stays off for good.
  assign enable_o = on_i && (falls < CAP);
endmodule : tfrc_mcu_model

// >>> sim/tfrc_ctrl_tb_top.sv
/*
  Self-checking bench of the thermal fault retry controller.
  Assumes short simulation values for the cool-down, retry and clear counts.
*/
`timescale 1ns/1ps
`include "tfrc_map.svh"
module tfrc_ctrl_tb_top import tfrc_pkg::*;;
  localparam int COOL  = 8;
  localparam int RETRY = 20;
  localparam int CLR   = 50;
  logic        sys_clk, rst, on, en, drive, latched, irq, psel, penable, pwrite;
  logic        pready, pslverr, last_err, fuse_latched;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  tfrc_flags_s flags;
  int          n_errors, checked;

  tfrc_ctrl #(.COOL_CYC(COOL), .RETRY_CYC(RETRY), .CLR_CYC(CLR)) u_tfrc_ctrl (
    .sys_clk_i(sys_clk), .reset_i(rst), .enable_i(en), .flags_i(flags),
    .drive_o(drive), .latched_o(latched), .irq_o(irq), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  tfrc_mcu_model u_tfrc_mcu_model (.sys_clk_i(sys_clk), .reset_i(rst), .on_i(on),
    .drive_i(drive), .enable_o(en));
  // Second controller trimmed to fuse behaviour; it shares every input.
  tfrc_ctrl #(.FAST_LIMIT(1), .SLOW_LIMIT(0), .COOL_CYC(COOL), .RETRY_CYC(RETRY),
    .CLR_CYC(CLR)) u_tfrc_ctrl_fuse (
    .sys_clk_i(sys_clk), .reset_i(rst), .enable_i(en), .flags_i(flags),
    .drive_o(), .latched_o(fuse_latched), .irq_o(), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(),
    .pslverr());

  // Clock at 200 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; entered just after a rising edge, holds until pready.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  // Wait for drive, apply a flag for hold cycles, then time the off phase.
  task fault(input logic [3:0] f, input int hold, output int off);
    off = 0;
    while (drive !== 1'b1 && off < 200) begin
      @(posedge sys_clk);
      off++;
    end
    flags <= tfrc_flags_s'(f);
    repeat (hold) @(posedge sys_clk);
    flags <= '0;
    @(posedge sys_clk);
    chk(32'(drive), 32'h0);
    off = hold + 1;
    while (drive !== 1'b1 && off < 200) begin
      @(posedge sys_clk);
      off++;
    end
  endtask : fault

  task t_regs;
    apb(1'b0, `TFRC_OFS_MASK, 32'h0);
    chk(rv, 32'h7);
    apb(1'b0, `TFRC_OFS_STATE, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'(last_err), 32'h1);
    chk(rv, 32'h0);
    chk(32'(fuse_latched), 32'h0);
  endtask : t_regs

  task t_retry;
    int off;
    on <= 1'b1;
    fault(4'h1, 1, off);
    chk(32'(off > COOL && off < RETRY), 32'h1);
    chk(32'(fuse_latched), 32'h1);
    fault(4'h1, 1, off);
    chk(32'(off > COOL && off < RETRY), 32'h1);
    fault(4'h8, 30, off);
    chk(32'(off > 30 && off < 36), 32'h1);
    fault(4'h1, 1, off);
    chk(32'(off > RETRY && off < RETRY + 6), 32'h1);
    apb(1'b0, `TFRC_OFS_STATE, 32'h0);
    chk(32'(rv[15:8]), 32'h4);
    fault(4'h4, 3, off);
    chk(32'(latched), 32'h1);
    chk(32'(drive), 32'h0);
  endtask : t_retry

  task t_clear;
    int off;
    on <= 1'b0;
    repeat (CLR + 3) @(posedge sys_clk);
    chk(32'(latched), 32'h0);
    chk(32'(fuse_latched), 32'h0);
    apb(1'b0, `TFRC_OFS_STATE, 32'h0);
    chk(32'(rv[15:8]), 32'h0);
    on <= 1'b1;
    fault(4'h2, 1, off);
    chk(32'(off), 32'h3);
  endtask : t_clear

  task t_irq;
    chk(32'(irq), 32'h1);
    apb(1'b0, `TFRC_OFS_EVENT, 32'h0);
    chk(rv, 32'h7);
    apb(1'b1, `TFRC_OFS_MASK, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'b1, `TFRC_OFS_MASK, 32'h7);
    apb(1'b1, `TFRC_OFS_EVENT, 32'h7);
    apb(1'b0, `TFRC_OFS_EVENT, 32'h0);
    chk(rv, 32'h0);
    chk(32'(irq), 32'h0);
  endtask : t_irq

  task end_sim;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // Main sequence: reset, then each scenario in turn.
  initial begin
    {rst, on, psel, penable, pwrite, paddr, pwdata, flags} = '0;
    rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_retry();
    t_clear();
    t_irq();
    end_sim();
  end

  // Watchdog far beyond the few hundred cycles the scenarios need.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end
endmodule : tfrc_ctrl_tb_top
